// file: design/smon_pkg.sv
`default_nettype none
package smon_pkg;
   // Register byte addresses on the control port.
   localparam int ADDR_W = 13;
   localparam logic [ADDR_W-1:0] ADDR_FINE_THR_LO = 13'h0106;
   localparam logic [ADDR_W-1:0] ADDR_FINE_THR_HI = 13'h0107;
   localparam logic [ADDR_W-1:0] ADDR_DC_CTRL = 13'h010C;
   localparam logic [ADDR_W-1:0] ADDR_SER_CTRL = 13'h0111;
   localparam logic [ADDR_W-1:0] ADDR_MON_CTRL = 13'h0112;
   localparam logic [ADDR_W-1:0] ADDR_PERIOD_0 = 13'h0113;
   localparam logic [ADDR_W-1:0] ADDR_PERIOD_1 = 13'h0114;
   localparam logic [ADDR_W-1:0] ADDR_PERIOD_2 = 13'h0115;
   localparam logic [ADDR_W-1:0] ADDR_RESULT_0 = 13'h0116;
   localparam logic [ADDR_W-1:0] ADDR_RESULT_1 = 13'h0117;
   localparam logic [ADDR_W-1:0] ADDR_RESULT_2 = 13'h0118;
   localparam logic [ADDR_W-1:0] ADDR_RESULT_3 = 13'h0119;
   localparam logic [ADDR_W-1:0] ADDR_RESULT_4 = 13'h011A;
   localparam logic [ADDR_W-1:0] ADDR_RESULT_5 = 13'h011B;
   // Field positions.
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_MODE_LO = 1;
   localparam int CTRL_MS_BIT = 4;
   localparam int SER_RMS_BIT = 0;
   localparam int SER_PEAK_BIT = 1;
   localparam int SER_THR_BIT = 2;
   localparam int DC_MON_BIT = 0;
   localparam int THR_HI_W = 5;
   // Data widths.
   localparam int SAMPLE_W = 14;
   localparam int LEVEL_W = 13;
   localparam int PER_W = 24;
   localparam int ACC_W = 24;
   localparam int PWR_W = 11;
   localparam int RES_W = 20;
   localparam int MS_SHIFT = RES_W - PWR_W;
   localparam int SH_W = 5;
   localparam int WORDS = 6;
   localparam int FRAME_W = WORDS * RES_W;
   localparam int BITS_W = 7;
   // Mode codes and reset values.
   typedef logic [1:0] smon_mode_t;
   localparam smon_mode_t MODE_RMS = 2'h0;
   localparam smon_mode_t MODE_PEAK = 2'h1;
   localparam int MODE_THR_BIT = 1;
   localparam logic [PER_W-1:0] PERIOD_RESET = 24'h0080;
   localparam logic [PER_W-1:0] TIMER_LAST = 24'h0001;
   localparam logic [7:0] BYTE_RESET = 8'h00;
endpackage : smon_pkg
`default_nettype wire

// file: design/smon_monitor.sv
`default_nettype none
module smon_monitor
   import smon_pkg::*;
(
   // Clock and reset.
   input wire logic clock,
   input wire logic resetn,
   // Samples and dc estimates, two's complement.
   input wire logic [SAMPLE_W-1:0] sampleA,
   input wire logic [SAMPLE_W-1:0] sampleB,
   input wire logic [SAMPLE_W-1:0] dcOffsetA,
   input wire logic [SAMPLE_W-1:0] dcOffsetB,
   // Control port byte access.
   input wire logic [ADDR_W-1:0] regAddr,
   input wire logic regWrite,
   input wire logic [7:0] regWrData,
   input wire logic regRead,
   output logic [7:0] regRdData,
   output logic regRdValid,
   // Serial result output.
   output logic serData,
   output logic serFrame,
   output logic serActive
);

////////////////////////////////////////////////////////////////////////////
   function automatic logic [LEVEL_W-1:0] levelOf(input logic [SAMPLE_W-1:0] s);
      logic [SAMPLE_W-1:0] a;
      a = s[SAMPLE_W-1] ? (~s + SAMPLE_W'(1)) : s;
      return a[SAMPLE_W-1] ? '1 : a[LEVEL_W-1:0];
   endfunction

   function automatic logic [ACC_W-1:0] satAdd(input logic [ACC_W-1:0] acc, input logic [PWR_W-1:0] p);
      logic [ACC_W:0] s;
      s = {1'b0, acc} + {{(ACC_W+1-PWR_W){1'b0}}, p};
      return s[ACC_W] ? '1 : s[ACC_W-1:0];
   endfunction

   function automatic logic [SH_W-1:0] ceilLog2(input logic [PER_W-1:0] p);
      logic [SH_W-1:0] r;
      r = (p == '0) ? SH_W'(PER_W) : '0;
      for (int i = 0; i < PER_W; i++)
         if (((PER_W+1)'(1) << i) < {1'b0, p})
            r = SH_W'(i + 1);
      return r;
   endfunction

   function automatic logic [RES_W-1:0] msOf(input logic [ACC_W-1:0] acc, input logic [SH_W-1:0] sh);
      logic [ACC_W+MS_SHIFT-1:0] w;
      w = {acc, {MS_SHIFT{1'b0}}} >> sh;
      return (|w[ACC_W+MS_SHIFT-1:RES_W]) ? '1 : w[RES_W-1:0];
   endfunction

   function automatic logic [RES_W-1:0] sqrtOf(input logic [2*RES_W-1:0] v);
      logic [RES_W-1:0] r;
      logic [RES_W-1:0] t;
      r = '0;
      for (int i = RES_W-1; i >= 0; i--)
      begin
         t = r | (RES_W'(1) << i);
         if (t * t <= v)
            r = t;
      end
      return r;
   endfunction

   function automatic logic [FRAME_W-1:0] frameOf(input logic [FRAME_W-1:0] w, input logic [WORDS-1:0] en);
      logic [FRAME_W-1:0] f;
      f = '0;
      for (int i = WORDS-1; i >= 0; i--)
         if (en[i])
            f = {f[FRAME_W-RES_W-1:0], w[i*RES_W +: RES_W]};
      for (int i = 0; i < WORDS; i++)
         if (!en[i])
            f = f << RES_W;
      return f;
   endfunction

   function automatic logic [BITS_W-1:0] bitsOf(input logic [WORDS-1:0] en);
      logic [BITS_W-1:0] n;
      n = '0;
      for (int i = 0; i < WORDS; i++)
         if (en[i])
            n = n + BITS_W'(RES_W);
      return n;
   endfunction

////////////////////////////////////////////////////////////////////////////
   logic [7:0] thrLo_reg, thrHi_reg, dcCtrl_reg, serCtrl_reg, ctrl_reg;
   logic [PER_W-1:0] period_reg;

   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         thrLo_reg <= BYTE_RESET;
         thrHi_reg <= BYTE_RESET;
         dcCtrl_reg <= BYTE_RESET;
         serCtrl_reg <= BYTE_RESET;
         ctrl_reg <= BYTE_RESET;
         period_reg <= PERIOD_RESET;
      end
      else if (regWrite)
      begin
         if (regAddr == ADDR_FINE_THR_LO) thrLo_reg <= regWrData;
         if (regAddr == ADDR_FINE_THR_HI) thrHi_reg <= regWrData;
         if (regAddr == ADDR_DC_CTRL) dcCtrl_reg <= regWrData;
         if (regAddr == ADDR_SER_CTRL) serCtrl_reg <= regWrData;
         if (regAddr == ADDR_MON_CTRL) ctrl_reg <= regWrData;
         if (regAddr == ADDR_PERIOD_0) period_reg[7:0] <= regWrData;
         if (regAddr == ADDR_PERIOD_1) period_reg[15:8] <= regWrData;
         if (regAddr == ADDR_PERIOD_2) period_reg[23:16] <= regWrData;
      end
   end

   // One threshold serves the crossing counters of both channels.
   wire logic [LEVEL_W-1:0] fineHighThreshold = {thrHi_reg[THR_HI_W-1:0], thrLo_reg};
   wire logic monEnable = ctrl_reg[CTRL_EN_BIT];
   wire smon_mode_t monMode = ctrl_reg[CTRL_MODE_LO +: 2];
   wire logic msSelect = ctrl_reg[CTRL_MS_BIT];
   wire logic doRms = monEnable & ((monMode == MODE_RMS) | serCtrl_reg[SER_RMS_BIT]);
   wire logic doPeak = monEnable & ((monMode == MODE_PEAK) | serCtrl_reg[SER_PEAK_BIT]);
   wire logic doThr = monEnable & (monMode[MODE_THR_BIT] | serCtrl_reg[SER_THR_BIT]);
   wire logic active = doRms | doPeak | doThr;
   wire logic dcEnable = dcCtrl_reg[DC_MON_BIT];

////////////////////////////////////////////////////////////////////////////
   logic [PER_W-1:0] timer_reg;
   logic running_reg, first_reg, latched_reg;
   wire logic activeStart = active & ~running_reg;
   wire logic periodEnd = active & running_reg & (timer_reg == TIMER_LAST);

   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         timer_reg <= '0;
         running_reg <= 1'b0;
         first_reg <= 1'b0;
         latched_reg <= 1'b0;
      end
      else
      begin
         running_reg <= active;
         latched_reg <= periodEnd;
         first_reg <= activeStart | periodEnd;
         if (!active)
            timer_reg <= '0;
         else if (activeStart | periodEnd)
            timer_reg <= period_reg;
         else
            timer_reg <= timer_reg - PER_W'(1);
      end
   end

////////////////////////////////////////////////////////////////////////////
   // The dc subtraction wraps rather than saturates; the estimate is small.
   logic [SAMPLE_W-1:0] monitor_period_length [2];
   logic [LEVEL_W-1:0] level [2];
   logic [2*LEVEL_W-1:0] square [2];
   logic [PWR_W-1:0] power [2];
   logic [LEVEL_W-1:0] peakNow [2];
   logic [ACC_W-1:0] accNow [2];
   logic [PER_W-1:0] cntNow [2];
   logic [LEVEL_W-1:0] peak_reg [2];
   logic [ACC_W-1:0] acc_reg [2];
   logic [PER_W-1:0] cnt_reg [2];
   logic [RES_W-1:0] holdRms_reg [2], holdPeak_reg [2], holdThr_reg [2], result [2];
   logic [RES_W-1:0] msVal [2];
   wire logic [SH_W-1:0] periodShift = ceilLog2(period_reg);

   assign monitor_period_length[0] = dcEnable ? sampleA - dcOffsetA : sampleA;
   assign monitor_period_length[1] = dcEnable ? sampleB - dcOffsetB : sampleB;

   for (genvar c = 0; c < 2; c++)
   begin : g_chan
      // Squaring the whole level and keeping the top bits matches a float square then fixed rounding down.
      assign level[c] = levelOf(monitor_period_length[c]);
      assign square[c] = level[c] * level[c];
      assign power[c] = square[c][2*LEVEL_W-1 -: PWR_W];
      assign peakNow[c] = (first_reg || level[c] > peak_reg[c]) ? level[c] : peak_reg[c];
      assign accNow[c] = first_reg ? {{(ACC_W-PWR_W){1'b0}}, power[c]} : satAdd(acc_reg[c], power[c]);
      assign cntNow[c] = (first_reg ? '0 : cnt_reg[c]) + PER_W'(level[c] > fineHighThreshold);
      assign msVal[c] = msOf(accNow[c], periodShift);
      assign result[c] = monMode[MODE_THR_BIT] ? holdThr_reg[c] :
                         (monMode == MODE_PEAK) ? holdPeak_reg[c] : holdRms_reg[c];

      always_ff @(posedge clock or negedge resetn)
      begin
         if (!resetn)
         begin
            peak_reg[c] <= '0;
            acc_reg[c] <= '0;
            cnt_reg[c] <= '0;
            holdRms_reg[c] <= '0;
            holdPeak_reg[c] <= '0;
            holdThr_reg[c] <= '0;
         end
         else if (active)
         begin
            peak_reg[c] <= peakNow[c];
            acc_reg[c] <= accNow[c];
            cnt_reg[c] <= cntNow[c];
            if (periodEnd && doRms)
               holdRms_reg[c] <= msSelect ? msVal[c] : sqrtOf({msVal[c], {RES_W{1'b0}}});
            if (periodEnd && doPeak)
               holdPeak_reg[c] <= RES_W'(peakNow[c]);
            if (periodEnd && doThr)
               holdThr_reg[c] <= (|cntNow[c][PER_W-1:RES_W]) ? '1 : cntNow[c][RES_W-1:0];
         end
      end
   end

////////////////////////////////////////////////////////////////////////////
   wire logic [7:0] rdMux =
      (regAddr == ADDR_FINE_THR_LO) ? thrLo_reg :
      (regAddr == ADDR_FINE_THR_HI) ? thrHi_reg :
      (regAddr == ADDR_DC_CTRL) ? dcCtrl_reg :
      (regAddr == ADDR_SER_CTRL) ? serCtrl_reg :
      (regAddr == ADDR_MON_CTRL) ? ctrl_reg :
      (regAddr == ADDR_PERIOD_0) ? period_reg[7:0] :
      (regAddr == ADDR_PERIOD_1) ? period_reg[15:8] :
      (regAddr == ADDR_PERIOD_2) ? period_reg[23:16] :
      (regAddr == ADDR_RESULT_0) ? result[0][7:0] :
      (regAddr == ADDR_RESULT_1) ? result[0][15:8] :
      (regAddr == ADDR_RESULT_2) ? {4'h0, result[0][19:16]} :
      (regAddr == ADDR_RESULT_3) ? result[1][7:0] :
      (regAddr == ADDR_RESULT_4) ? result[1][15:8] :
      (regAddr == ADDR_RESULT_5) ? {4'h0, result[1][19:16]} : BYTE_RESET;

   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         regRdData <= BYTE_RESET;
         regRdValid <= 1'b0;
      end
      else
      begin
         regRdValid <= regRead;
         if (regRead)
            regRdData <= rdMux;
      end
   end

////////////////////////////////////////////////////////////////////////////
   // A frame is at most 120 bits; a period shorter than the enabled frame's length reloads the shifter before the frame has finished.
   logic [FRAME_W-1:0] shift_reg;
   logic [BITS_W-1:0] bitsLeft_reg;
   logic serFrame_reg;
   wire logic [2:0] serEn = serCtrl_reg[2:0] & {3{monEnable}};
   wire logic [WORDS-1:0] wordEn = {serEn[0], serEn[1], serEn[2], serEn[0], serEn[1], serEn[2]};
   wire logic [FRAME_W-1:0] words = {holdRms_reg[0], holdPeak_reg[0], holdThr_reg[0],
                                     holdRms_reg[1], holdPeak_reg[1], holdThr_reg[1]};
   wire logic serLoad = latched_reg & (|serEn);
   wire logic [FRAME_W-1:0] frameNext = frameOf(words, wordEn);

   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         shift_reg <= '0;
         bitsLeft_reg <= '0;
         serFrame_reg <= 1'b0;
      end
      else
      begin
         serFrame_reg <= serLoad;
         if (serLoad)
         begin
            shift_reg <= frameNext;
            bitsLeft_reg <= bitsOf(wordEn);
         end
         else if (bitsLeft_reg != '0)
         begin
            shift_reg <= shift_reg << 1;
            bitsLeft_reg <= bitsLeft_reg - BITS_W'(1);
         end
      end
   end

   assign serData = shift_reg[FRAME_W-1];
   assign serFrame = serFrame_reg;
   assign serActive = bitsLeft_reg != '0;

////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);

   property p_load; activeStart |=> timer_reg == $past(period_reg) && first_reg; endproperty
   a_load: assert property (p_load) else $error("timer not loaded on enable");
   property p_reload; periodEnd |=> first_reg && timer_reg == $past(period_reg); endproperty
   a_reload: assert property (p_reload) else $error("timer not reloaded at period end");
   property p_peak; periodEnd && doPeak |=> holdPeak_reg[0] == RES_W'($past(peakNow[0])); endproperty
   a_peak: assert property (p_peak) else $error("peak not latched");
   property p_count; active && !first_reg && running_reg ##1 active |->
      cnt_reg[1] == $past(cnt_reg[1]) + PER_W'($past(level[1] > fineHighThreshold)); endproperty
   a_count: assert property (p_count) else $error("crossing count step wrong");
   property p_clear; first_reg && active |-> cntNow[0] <= PER_W'(1); endproperty
   a_clear: assert property (p_clear) else $error("count not restarted");
   property p_idle; !active |=> timer_reg == '0 && $stable(holdRms_reg[0]) && $stable(holdThr_reg[1]); endproperty
   a_idle: assert property (p_idle) else $error("disabled block not idle");
   property p_enable; !monEnable |-> !active; endproperty
   a_enable: assert property (p_enable) else $error("active while disabled");
   property p_mode; monEnable && monMode[MODE_THR_BIT] |-> doThr && !(monMode == MODE_PEAK); endproperty
   a_mode: assert property (p_mode) else $error("mode decode wrong");
   property p_read; regRead && regAddr == ADDR_RESULT_3 |=> regRdValid && regRdData == $past(result[1][7:0]);
   endproperty
   a_read: assert property (p_read) else $error("result byte read wrong");
   property p_frame; serFrame |-> serActive && serData == $past(frameNext[FRAME_W-1]); endproperty
   a_frame: assert property (p_frame) else $error("frame start wrong");

   property p_cPeriod; periodEnd && doRms; endproperty
   c_period: cover property (p_cPeriod);
   property p_cSerial; serFrame ##1 serActive [*8]; endproperty
   c_serial: cover property (p_cSerial);
   property p_cCross; periodEnd && doThr && cntNow[0] > PER_W'(1); endproperty
   c_cross: cover property (p_cCross);

endmodule // smon_monitor
`default_nettype wire

// file: dv/smon_ser_sink.sv
`default_nettype none
module smon_ser_sink
   import smon_pkg::*;
#(
   parameter int FRAME_BITS = 40
)
(
   // Clock and reset.
   input wire logic clock,
   input wire logic resetn,
   // Serial result stream from the monitor.
   input wire logic serData,
   input wire logic serFrame,
   input wire logic serActive,
   // Last complete frame and a count of frames seen.
   output logic [FRAME_BITS-1:0] frameWord,
   output logic [7:0] doneCount
);
   timeunit 1ns;
   timeprecision 1ps;

   ////////////////////////////////////////////////////////////////////////////////
   logic [FRAME_BITS-1:0] shiftReg;
   logic prevActive;

   // The sink only takes a frame once the stream has gone quiet, so a
   // truncated frame never reaches the comparison as if it were whole.
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         shiftReg <= '0;
         prevActive <= 1'b0;
         frameWord <= '0;
         doneCount <= 8'h00;
      end
      else
      begin
         if (serActive)
            shiftReg <= {shiftReg[FRAME_BITS-2:0], serData};
         if (serFrame)
            shiftReg <= {{(FRAME_BITS-1){1'b0}}, serData};
         prevActive <= serActive;
         if (prevActive && !serActive)
         begin
            frameWord <= shiftReg;
            doneCount <= doneCount + 8'h01;
         end
      end
   end
endmodule // smon_ser_sink
`default_nettype wire

// file: dv/tb_adc_signal_monitor.sv
`default_nettype none
module tb_adc_signal_monitor
   import smon_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ps;

   ////////////////////////////////////////////////////////////////////////////////
   logic clock = 1'b0;
   logic resetn = 1'b0;
   logic [SAMPLE_W-1:0] sampleA = '0;
   logic [SAMPLE_W-1:0] sampleB = '0;
   logic [SAMPLE_W-1:0] dcOffsetA = '0;
   logic [SAMPLE_W-1:0] dcOffsetB = '0;
   logic [ADDR_W-1:0] regAddr = '0;
   logic regWrite = 1'b0;
   logic [7:0] regWrData = 8'h00;
   logic regRead = 1'b0;
   logic [7:0] regRdData;
   logic regRdValid;
   logic serData, serFrame, serActive;
   logic [39:0] frameWord;
   logic [7:0] doneCount;
   logic [39:0] res;
   logic [7:0] rb;
   int badCount = 0;
   int testsRun = 0;
   localparam logic [ADDR_W-1:0] RST_ADDR [6] = '{ADDR_MON_CTRL, ADDR_SER_CTRL, ADDR_PERIOD_0,
      ADDR_PERIOD_1, ADDR_PERIOD_2, 13'h1FF0};
   localparam logic [7:0] RST_VAL [6] = '{8'h00, 8'h00, PERIOD_RESET[7:0], PERIOD_RESET[15:8],
      PERIOD_RESET[23:16], 8'h00};

   initial
   begin
      forever #2 clock = ~clock;
   end

   smon_monitor u_dut (.clock(clock), .resetn(resetn), .sampleA(sampleA), .sampleB(sampleB),
      .dcOffsetA(dcOffsetA), .dcOffsetB(dcOffsetB), .regAddr(regAddr), .regWrite(regWrite),
      .regWrData(regWrData), .regRead(regRead), .regRdData(regRdData), .regRdValid(regRdValid),
      .serData(serData), .serFrame(serFrame), .serActive(serActive));

   smon_ser_sink #(.FRAME_BITS(40)) u_sink (.clock(clock), .resetn(resetn), .serData(serData),
      .serFrame(serFrame), .serActive(serActive), .frameWord(frameWord), .doneCount(doneCount));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic giveVerdict();
      $display("checks %0d mismatches %0d", testsRun, badCount);
      if (badCount == 0 && testsRun > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
      testsRun++;
      if (got !== exp)
      begin
         badCount++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk_val(input string what, input logic [39:0] exp, input logic [39:0] got);
      testsRun++;
      if (got !== exp)
      begin
         badCount++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
      @(posedge clock);
      regAddr <= a;
      regWrData <= d;
      regWrite <= 1'b1;
      @(posedge clock);
      regWrite <= 1'b0;
   endtask

   // The answer stands in the cycle after the request edge and is taken at the edge that ends it.
   task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] d);
      int n;
      @(posedge clock);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clock);
      regRead <= 1'b0;
      n = 0;
      @(posedge clock);
      while (regRdValid !== 1'b1 && n < 4)
      begin
         @(posedge clock);
         n++;
      end
      if (n >= 4)
      begin
         badCount++;
         giveVerdict();
      end
      d = regRdData;
   endtask

   // Packs channel A above channel B, the same order the serial frame uses.
   task automatic rd_res(output logic [39:0] v);
      logic [7:0] b [6];
      for (int i = 0; i < 6; i++)
         rd(ADDR_RESULT_0 + 13'(i), b[i]);
      v = {b[2][3:0], b[1], b[0], b[5][3:0], b[4], b[3]};
   endtask

   task automatic wait_frames(input int cnt);
      logic [7:0] start;
      int k;
      start = doneCount;
      k = 0;
      while (int'(8'(doneCount - start)) < cnt && k < 5000)
      begin
         @(posedge clock);
         k++;
      end
      if (k >= 5000)
      begin
         badCount++;
         giveVerdict();
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (3) @(posedge clock);
      resetn <= 1'b1;
      for (int i = 0; i < 6; i++)
      begin
         rd(RST_ADDR[i], rb);
         chk_byte("reset_value", RST_VAL[i], rb);
      end
      $display("test reset_values done");

      // Peak, dc removal on both channels, results streamed and read back.
      sampleA <= 14'h0064;
      sampleB <= 14'h3F38;
      dcOffsetA <= 14'h0014;
      dcOffsetB <= 14'h3FF6;
      wr(ADDR_DC_CTRL, 8'h01);
      wr(ADDR_PERIOD_0, 8'h80);
      wr(ADDR_PERIOD_1, 8'h00);
      wr(ADDR_PERIOD_2, 8'h00);
      wr(ADDR_SER_CTRL, 8'h02);
      wr(ADDR_MON_CTRL, 8'h03);
      wait_frames(2);
      chk_val("peak_frame", {20'd80, 20'd190}, frameWord);
      rd_res(res);
      chk_val("peak_regs", {20'd80, 20'd190}, res);
      sampleB <= 14'h3F6A;
      wait_frames(3);
      chk_val("peak_reseed", {20'd80, 20'd140}, frameWord);
      $display("test peak done");

      // Threshold count; channel B sits exactly on the threshold.
      wr(ADDR_SER_CTRL, 8'h00);
      wr(ADDR_DC_CTRL, 8'h00);
      wr(ADDR_FINE_THR_LO, 8'h96);
      wr(ADDR_FINE_THR_HI, 8'h00);
      sampleA <= 14'h0097;
      foreach (RST_VAL[m])
      begin
         if (m < 2)
         begin
            wr(ADDR_MON_CTRL, (m == 0) ? 8'h05 : 8'h07);
            repeat (400) @(posedge clock);
            rd_res(res);
            chk_val("thr_count", {20'd128, 20'd0}, res);
         end
      end
      $display("test threshold done");

      // Disabled block keeps its results; result bytes ignore writes.
      // The mode bits stay on threshold so the read mux keeps showing the held counts.
      wr(ADDR_MON_CTRL, 8'h04);
      sampleA <= 14'h0000;
      wr(ADDR_RESULT_0, 8'hFF);
      repeat (400) @(posedge clock);
      rd_res(res);
      chk_val("hold_off", {20'd128, 20'd0}, res);
      $display("test disable_hold done");

      // Rms (square-root) path over silent inputs must settle to zero.
      sampleB <= 14'h0000;
      wr(ADDR_MON_CTRL, 8'h01);
      repeat (400) @(posedge clock);
      rd_res(res);
      chk_val("rms_zero", 40'h0, res);
      // A half-scale input reads -6 dBFS: 2^19 as rms and 2^18 as mean-square.
      sampleA <= 14'h1000;
      sampleB <= 14'h3000;
      wr(ADDR_SER_CTRL, 8'h01);
      wait_frames(2);
      chk_val("rms_frame", {20'h8_0000, 20'h8_0000}, frameWord);
      wr(ADDR_MON_CTRL, 8'h11);
      repeat (400) @(posedge clock);
      rd_res(res);
      chk_val("ms_regs", {20'h4_0000, 20'h4_0000}, res);
      $display("test rms done");
      giveVerdict();
   end
endmodule // tb_adc_signal_monitor
`default_nettype wire
